// ---- src/h3s_pkg.sv ----
// Purpose: shared types and constants of the measurement sequencer
// Assumes: main clock of 10 MHz, link clock from the serial slave side
// Notes: every timing count is derived here from its time in its own unit
//
// Functional notes
// - temperature included after reset until reconfigured
// - host may drop temperature for faster cycles
// - temperature reported as raw bits 11 to 2
// - rebuilt temperature word is two's complement
// - power-down mode performs no conversions at all
// - low-power cycles from internal timer, 10/160 Hz
// - fast mode converts continuously at typical rates
// - master-controlled cycles start only on trigger
// - low pulse of 2.5 us ends each cycle
// - fast mode restarts right after cycle end
// - other modes start only on a trigger
// - full set converts X, Y, Z, then T
// - reduced sets skip omitted channels entirely
package h3s_pkg;

	// operating modes selected by the host
	typedef enum logic [1:0] {
		MODE_POWER_DOWN,
		MODE_LOW_POWER,
		MODE_FAST,
		MODE_MASTER
	} h3s_mode_t;

	// channel sets that one cycle can cover
	typedef enum logic [1:0] {
		SET_XYZT,
		SET_XYZ,
		SET_XY
	} h3s_chset_t;

	// conversion channel in cycle order
	typedef enum logic [1:0] {
		CH_X,
		CH_Y,
		CH_Z,
		CH_T
	} h3s_chan_t;

	// sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CONV
	} h3s_state_t;

	// host configuration word
	typedef struct packed {
		h3s_mode_t mode; // operating mode
		logic lp_fast; // low-power rate: 1 selects 160 Hz
		h3s_chset_t chset; // channels per cycle
		logic int_en; // end-of-conversion pulse enable
	} h3s_cfg_t;

	// result set seen by the readout side
	typedef struct packed {
		logic [11:0] field_x_channel; // x field, two's complement
		logic [11:0] field_y_channel; // y field, two's complement
		logic [11:0] field_z_channel; // z field, two's complement
		logic [9:0] temp; // temperature, raw bits 11..2
	} h3s_result_t;

	// configuration after reset: power-down, all four channels
	localparam h3s_cfg_t CFG_RESET = '{
		mode: MODE_POWER_DOWN,
		lp_fast: 1'h0,
		chset: SET_XYZT,
		int_en: 1'h1
	};

	// field layout of the temperature slice
	localparam int TEMP_HI = 11;
	localparam int TEMP_LO = 2;
	localparam int RAW_W = 12;

	// main clock
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;

	// end-of-conversion pulse, nanoseconds
	localparam int INT_MIN_NS = 1800;
	localparam int INT_NOM_NS = 2500;
	localparam int INT_MAX_NS = 3200;
	localparam int INT_CYC = (INT_NOM_NS * CLK_MHZ) / 1000;
	localparam int INT_CW = 6;

	// low-power update rates, hertz
	localparam int LP_SLOW_HZ = 10;
	localparam int LP_FAST_HZ = 160;
	localparam int LP_SLOW_CYC = CLK_HZ / LP_SLOW_HZ;
	localparam int LP_FAST_CYC = CLK_HZ / LP_FAST_HZ;
	localparam int LP_CW = 20;

	// readout windows kept by the host, microseconds
	localparam int RD1_MIN_US = 30;
	localparam int RD1_MAX_US = 50;
	localparam int RD1_SR_MIN_US = 42;
	localparam int RD1_SR_MAX_US = 70;
	localparam int RDN_MIN_US = 32;
	localparam int RDN_MAX_US = 54;
	localparam int RDN_SR_MIN_US = 44;
	localparam int RDN_SR_MAX_US = 74;

	// host temperature conversion figures
	localparam int TEMP_NOM_CNT = 1180;
	localparam int TEMP_REF_DEGC = 25;

	// last channel of a cycle for a channel set
	function automatic h3s_chan_t last_chan(input h3s_chset_t s);
		case (s)
			SET_XYZ: last_chan = CH_Z;
			SET_XY: last_chan = CH_Y;
			default: last_chan = CH_T;
		endcase
	endfunction

	// successor channel in conversion order
	function automatic h3s_chan_t next_chan(input h3s_chan_t c);
		case (c)
			CH_X: next_chan = CH_Y;
			CH_Y: next_chan = CH_Z;
			default: next_chan = CH_T;
		endcase
	endfunction

endpackage

// ---- src/h3s_evt_xing.sv ----
// Purpose: carries a one-cycle event from the link clock to the main clock
// Assumes: events are spaced by at least three destination cycles
// Notes: toggle plus two-flop synchroniser plus edge detect
`timescale 1ns/1ps
`default_nettype none
module h3s_evt_xing (
	input wire logic src_clk_i, // link clock
	input wire logic src_rstn_i, // link reset, active low
	input wire logic src_pulse_i, // event, one link cycle
	input wire logic dst_clk_i, // main clock
	input wire logic dst_rstn_i, // main reset, active low
	output logic dst_pulse_o // event, one main cycle
);

	logic tgl; // source toggle, flips per event
	logic next_tgl;
	logic meta; // first stage, read only by the second
	logic sync; // second stage
	logic seen; // last toggle value acted on
	logic next_pulse;

	// toggle on each source event
	always_comb
	begin
		next_tgl = tgl ^ src_pulse_i;
	end

	always_ff @(posedge src_clk_i or negedge src_rstn_i)
	begin
		if (!src_rstn_i)
			tgl <= 1'h0;
		else
			tgl <= next_tgl;
	end

	// edge of the synchronised toggle is one event
	always_comb
	begin
		next_pulse = sync ^ seen;
	end

	always_ff @(posedge dst_clk_i or negedge dst_rstn_i)
	begin
		if (!dst_rstn_i)
		begin
			meta <= 1'h0;
			sync <= 1'h0;
			seen <= 1'h0;
			dst_pulse_o <= 1'h0;
		end
		else
		begin
			meta <= tgl;
			sync <= meta;
			seen <= sync;
			dst_pulse_o <= next_pulse;
		end
	end

endmodule
`default_nettype wire

// ---- src/h3s_seq.sv ----
// Purpose: measurement cycle sequencer with end-of-conversion pulse
// Assumes: conversion engine on the main clock, trigger from link domain
// Notes: channel set is sampled per cycle; mode and int_en changes act at once
`timescale 1ns/1ps
`default_nettype none
module h3s_seq #(
	parameter int unsigned LPW = h3s_pkg::LP_CW, // low-power counter width
	parameter logic [LPW-1:0] LP_SLOW = LPW'(h3s_pkg::LP_SLOW_CYC), // 10 Hz
	parameter logic [LPW-1:0] LP_FAST = LPW'(h3s_pkg::LP_FAST_CYC) // 160 Hz
) (
	input wire logic mclk_i, // main clock, 10 MHz
	input wire logic rstn_i, // main reset, active low
	input wire logic link_clk_i, // serial link clock
	input wire logic link_rstn_i, // link reset, active low
	input wire logic link_trig_i, // host trigger, one link cycle
	input wire logic cfg_wr_i, // config write strobe
	input wire h3s_pkg::h3s_cfg_t cfg_i, // config word
	input wire logic adc_done_i, // conversion finished, one cycle
	input wire logic [11:0] adc_data_i, // raw conversion value
	output logic adc_start_o, // start conversion, one cycle
	output var h3s_pkg::h3s_chan_t adc_chan_o, // channel being converted
	output var h3s_pkg::h3s_result_t result_o, // latest results
	output logic int_n_o, // end-of-conversion, active low
	output logic busy_o // cycle in progress
);
	import h3s_pkg::*;

	localparam int INT_LEN = INT_CYC; // pulse length checked below

	logic trig_evt; // host trigger on main clock
	h3s_cfg_t act_cfg; // active configuration
	h3s_cfg_t next_act_cfg;
	logic cfg_seen; // host wrote config since reset
	logic next_cfg_seen;
	logic [LPW-1:0] lp_cnt; // low-power period counter
	logic [LPW-1:0] next_lp_cnt;
	logic [LPW-1:0] lp_period; // selected period in cycles
	logic lp_tick; // low-power timer trigger
	logic next_lp_tick;
	logic trig_pend; // host trigger waiting for idle
	logic next_trig_pend;
	logic go; // start a cycle from idle
	h3s_state_t state; // sequencer state
	h3s_state_t next_state;
	h3s_chan_t ch; // channel being converted
	h3s_chan_t next_ch;
	h3s_chset_t cyc_set; // channel set of this cycle
	h3s_chset_t next_cyc_set;
	logic next_adc_start;
	h3s_result_t next_result;
	logic [INT_CW-1:0] int_cnt; // remaining pulse cycles
	logic [INT_CW-1:0] next_int_cnt;
	logic next_int_n;
	logic next_busy;
	logic end_now; // cycle completes in this cycle

	// trigger from the link side crosses by toggle
	h3s_evt_xing u_trig (
		.src_clk_i(link_clk_i),
		.src_rstn_i(link_rstn_i),
		.src_pulse_i(link_trig_i),
		.dst_clk_i(mclk_i),
		.dst_rstn_i(rstn_i),
		.dst_pulse_o(trig_evt)
	);

	// configuration register, takes the word on a write strobe
	always_comb
	begin
		next_act_cfg = act_cfg;
		next_cfg_seen = cfg_seen;
		if (cfg_wr_i)
		begin
			next_act_cfg = cfg_i;
			next_cfg_seen = 1'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			act_cfg <= CFG_RESET;
			cfg_seen <= 1'h0;
		end
		else
		begin
			act_cfg <= next_act_cfg;
			cfg_seen <= next_cfg_seen;
		end
	end

	// periodic internal trigger in low power
	always_comb
	begin
		lp_period = act_cfg.lp_fast ? LP_FAST : LP_SLOW;
		next_lp_cnt = lp_cnt + LPW'(1);
		next_lp_tick = 1'h0;
		if (act_cfg.mode != MODE_LOW_POWER)
			// counter parked outside low power
			next_lp_cnt = '0;
		else if (lp_cnt >= lp_period - LPW'(1))
		begin
			next_lp_cnt = '0;
			next_lp_tick = 1'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			lp_cnt <= '0;
			lp_tick <= 1'h0;
		end
		else
		begin
			lp_cnt <= next_lp_cnt;
			lp_tick <= next_lp_tick;
		end
	end

	// cycles start from idle on a trigger, or at once in fast mode
	always_comb
	begin
		go = 1'h0;
		if (state == ST_IDLE)
		begin
			case (act_cfg.mode)
				// fast mode never waits for a trigger
				MODE_FAST: go = 1'h1;
				MODE_LOW_POWER: go = lp_tick | trig_pend;
				MODE_MASTER: go = trig_pend;
				default: go = 1'h0;
			endcase
		end
	end

	// host trigger held until a cycle can start
	always_comb
	begin
		next_trig_pend = trig_pend;
		if (go)
			next_trig_pend = 1'h0;
		if (act_cfg.mode == MODE_POWER_DOWN || act_cfg.mode == MODE_FAST)
			// triggers mean nothing here, drop them
			next_trig_pend = 1'h0;
		else if (trig_evt)
			// a trigger landing on the clear still counts
			next_trig_pend = 1'h1;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			trig_pend <= 1'h0;
		else
			trig_pend <= next_trig_pend;
	end

	// sequencer: channel stepping, result capture, pulse timing
	always_comb
	begin
		next_state = state;
		next_ch = ch;
		next_cyc_set = cyc_set;
		next_adc_start = 1'h0;
		next_result = result_o;
		next_int_cnt = (int_cnt != '0) ? int_cnt - INT_CW'(1) : '0;
		end_now = 1'h0;
		case (state)
			ST_IDLE:
			begin
				// channel set frozen for the cycle
				// a reduced set leaves temperature out
				if (go)
				begin
					next_state = ST_CONV;
					next_ch = CH_X;
					next_cyc_set = act_cfg.chset;
					next_adc_start = 1'h1;
				end
			end
			ST_CONV:
			begin
				// power-down abandons the cycle at once
				if (act_cfg.mode == MODE_POWER_DOWN)
					next_state = ST_IDLE;
				else if (adc_done_i)
				begin
					case (ch)
						CH_X: next_result.field_x_channel = adc_data_i;
						CH_Y: next_result.field_y_channel = adc_data_i;
						CH_Z: next_result.field_z_channel = adc_data_i;
						// low two bits dropped, sign kept
						// top bit stays the sign weight
						default: next_result.temp = adc_data_i[TEMP_HI:TEMP_LO];
					endcase
					// cycle ends at the set's last channel
					if (ch == last_chan(cyc_set))
					begin
						end_now = 1'h1;
						if (act_cfg.int_en)
							next_int_cnt = INT_CW'(INT_CYC);
						// fast mode starts over at once
						if (act_cfg.mode == MODE_FAST)
						begin
							next_ch = CH_X;
							next_cyc_set = act_cfg.chset;
							next_adc_start = 1'h1;
						end
						else
							next_state = ST_IDLE;
					end
					else
					begin
						next_ch = next_chan(ch);
						next_adc_start = 1'h1;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_int_n = (next_int_cnt == '0);
		next_busy = (next_state == ST_CONV);
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state <= ST_IDLE;
			ch <= CH_X;
			cyc_set <= SET_XYZT;
			adc_start_o <= 1'h0;
			result_o <= '0;
			int_cnt <= '0;
			int_n_o <= 1'h1;
			busy_o <= 1'h0;
		end
		else
		begin
			state <= next_state;
			ch <= next_ch;
			cyc_set <= next_cyc_set;
			adc_start_o <= next_adc_start;
			result_o <= next_result;
			int_cnt <= next_int_cnt;
			int_n_o <= next_int_n;
			busy_o <= next_busy;
		end
	end

	// channel driven to the engine is the stepping register
	assign adc_chan_o = ch;

	// helper: length of the current low pulse
	logic [7:0] low_len;
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			low_len <= '0;
		else if (!int_n_o)
			low_len <= low_len + 8'h01;
		else
			low_len <= '0;
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	a_reset_temp_on: assert property (!cfg_seen |-> act_cfg.chset == SET_XYZT)
		else $error("temperature channel not active after reset");

	a_set_dropped: assert property (adc_start_o && cyc_set != SET_XYZT
		|-> adc_chan_o != CH_T)
		else $error("temperature converted in reduced set");

	a_temp_slice: assert property (state == ST_CONV && adc_done_i
		&& ch == CH_T && act_cfg.mode != MODE_POWER_DOWN
		|=> {result_o.temp, 2'h0} == ($past(adc_data_i) & 12'hffc))
		else $error("temperature field not raw bits 11..2");

	a_pd_quiet: assert property (act_cfg.mode == MODE_POWER_DOWN
		|=> !adc_start_o && !busy_o)
		else $error("conversion started in power-down");

	a_lp_tick_mode: assert property (lp_tick
		|-> $past(act_cfg.mode) == MODE_LOW_POWER)
		else $error("low-power tick outside low-power mode");

	a_trig_start: assert property (state == ST_IDLE && trig_pend
		&& act_cfg.mode == MODE_MASTER
		|=> adc_start_o && adc_chan_o == CH_X && busy_o)
		else $error("master trigger did not start a cycle");

	a_pulse_width: assert property ($rose(int_n_o)
		|-> low_len == INT_LEN)
		else $error("end-of-conversion pulse length wrong");

	a_pulse_start: assert property (end_now && act_cfg.int_en
		|=> !int_n_o)
		else $error("no pulse at cycle end");

	a_fast_restart: assert property (end_now && act_cfg.mode == MODE_FAST
		|=> adc_start_o && adc_chan_o == CH_X)
		else $error("fast mode did not restart at once");

	a_idle_hold: assert property (state == ST_IDLE && !go
		|=> !adc_start_o && !busy_o)
		else $error("cycle started without a trigger");

	a_chan_order: assert property (state == ST_CONV && adc_done_i
		&& act_cfg.mode != MODE_POWER_DOWN && ch != last_chan(cyc_set)
		|=> adc_start_o && adc_chan_o == next_chan($past(ch)))
		else $error("channel order broken");

	a_set_end: assert property (end_now && act_cfg.mode != MODE_FAST
		|=> !busy_o && !adc_start_o)
		else $error("cycle did not end at last channel");

	c_full_cycle: cover property (end_now && cyc_set == SET_XYZT);
	c_xy_cycle: cover property (end_now && cyc_set == SET_XY);
	c_fast_loop: cover property (end_now && act_cfg.mode == MODE_FAST);
	c_pulse_done: cover property ($rose(int_n_o));
	c_host_trig: cover property (trig_evt && act_cfg.mode == MODE_MASTER);

endmodule
`default_nettype wire

// ---- verification/h3s_adc_model.sv ----
// Purpose: conversion engine stand-in for the sequencer bench
// Assumes: one done per start, answer delay chosen by the bench
// Notes: data is inverted on idle cycles so a stale sample never matches
`timescale 1ns/1ps
`default_nettype none
module h3s_adc_model (
	input wire logic mclk_i, // main clock
	input wire logic rstn_i, // reset, active low
	input wire logic start_i, // start pulse from the sequencer
	input wire h3s_pkg::h3s_chan_t chan_i, // channel to convert
	input wire logic [7:0] lat_i, // answer delay in cycles
	input wire logic [11:0] ofs_i, // base of the sample pattern
	output logic done_o, // sample valid, one cycle
	output logic [11:0] data_o // sample value
);
	import h3s_pkg::*;
	logic run; // conversion in flight
	logic [7:0] cnt; // cycles left before the answer
	h3s_chan_t ch; // channel latched at start
	// one conversion at a time, answered after lat_i plus one cycles
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			run <= 1'b0;
			cnt <= 8'h00;
			ch <= CH_X;
			done_o <= 1'b0;
			data_o <= 12'h000;
		end
		else
		begin
			done_o <= 1'b0;
			data_o <= ~data_o; // released bus keeps moving
			if (start_i)
			begin
				run <= 1'b1;
				cnt <= lat_i;
				ch <= chan_i;
			end
			else if (run && cnt == 8'h00)
			begin
				run <= 1'b0;
				done_o <= 1'b1;
				// each channel gets its own pattern so mix-ups show
				data_o <= ofs_i ^ {2'h0, ch, 6'h00, ch};
			end
			else if (run)
				cnt <= cnt - 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the measurement sequencer
// Assumes: engine model answers every start; trigger sent on link clock
// Notes: low-power periods are shortened to 200 and 50 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import h3s_pkg::*;
	localparam int LIMIT = 20000; // cycle ceiling for the run
	logic mclk = 1'b0; // main clock
	logic rstn = 1'b0; // main reset, active low
	logic lclk = 1'b0; // link clock, still outside frames
	logic lrstn = 1'b0; // link reset, active low
	logic ltrig = 1'b0; // host trigger
	logic cfg_wr = 1'b0; // config strobe
	h3s_cfg_t cfg = CFG_RESET; // config word
	logic [7:0] lat = 8'h02; // engine answer delay
	logic [11:0] ofs = 12'h0000; // sample pattern base
	logic adc_done; // engine done
	logic [11:0] adc_data; // engine sample
	logic adc_start; // sequencer start
	h3s_chan_t adc_chan; // sequencer channel
	h3s_result_t result; // result set
	logic int_n; // end pulse, active low
	logic busy; // cycle running
	logic [7:0] order; // channel order of recent starts
	int n_start; // starts seen
	int n_int; // pulses seen
	int wid; // width of last pulse
	int low; // running pulse width
	int tick; // cycle counter for the timeout
	int rise; // cycle at which the last pulse was counted
	int deg; // host temperature less the 25 degree reference, hundredths of a degree
	// expected result sets of the three master-mode runs
	localparam logic [45:0] RES_XYZT = {12'h8a3, 12'h9a2, 12'haa1, 10'h2e8};
	localparam logic [45:0] RES_XYZ = {12'h100, 12'h001, 12'h302, 10'h2e8};
	localparam logic [45:0] RES_XY = {12'h404, 12'h505, 12'h302, 10'h2e8};
	int miscompares = 0;
	int num_checks = 0;

	h3s_seq #(.LP_SLOW(20'h0_00c8), .LP_FAST(20'h0_0032)) u_dut (
		.mclk_i(mclk), .rstn_i(rstn), .link_clk_i(lclk),
		.link_rstn_i(lrstn), .link_trig_i(ltrig), .cfg_wr_i(cfg_wr),
		.cfg_i(cfg), .adc_done_i(adc_done), .adc_data_i(adc_data),
		.adc_start_o(adc_start), .adc_chan_o(adc_chan),
		.result_o(result), .int_n_o(int_n), .busy_o(busy));

	h3s_adc_model u_adc (.mclk_i(mclk), .rstn_i(rstn),
		.start_i(adc_start), .chan_i(adc_chan), .lat_i(lat),
		.ofs_i(ofs), .done_o(adc_done), .data_o(adc_data));

	// main clock, 100 ns
	initial
		forever #50 mclk = ~mclk;

	// monitor sees pre-edge values of the registered outputs
	always @(posedge mclk)
	begin
		tick++;
		if (rstn && adc_start)
		begin
			order = {order[5:0], adc_chan};
			n_start++;
		end
		if (rstn && !int_n)
			low++;
		else if (low != 0)
		begin
			n_int++;
			wid = low;
			low = 0;
			rise = tick;
		end
		// ceiling checked last so that nothing follows the finish
		if (tick == LIMIT)
		begin
			miscompares++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic cfg_write(input h3s_mode_t m, input logic lpf,
		input h3s_chset_t s, input logic ie);
		@(posedge mclk);
		#1;
		cfg_wr = 1'b1;
		cfg = '{mode: m, lp_fast: lpf, chset: s, int_en: ie};
		@(posedge mclk);
		#1;
		cfg_wr = 1'b0;
		n_start = 0;
		n_int = 0;
	endtask

	// one link cycle of trigger, clock stopped before and after
	task automatic trig();
		#37;
		ltrig = 1'b1;
		repeat (2) #7.5 lclk = ~lclk;
		ltrig = 1'b0;
		repeat (6) #7.5 lclk = ~lclk;
	endtask

	// host times its first read from the end pulse, the next read from the first
	task automatic wait_rd(input int base, input int us);
		while (tick < base + us * CLK_MHZ)
			@(posedge mclk);
		#1;
	endtask

	task automatic run_one(input logic [11:0] o);
		int i;
		ofs = o;
		order = 8'h00;
		n_start = 0;
		n_int = 0;
		trig();
		for (i = 0; i < 40 && busy !== 1'b1; i++)
			@(posedge mclk);
		for (i = 0; i < 400 && busy !== 1'b0; i++)
			@(posedge mclk);
		// let the end pulse finish before counting it
		repeat (30) @(posedge mclk);
		#1;
	endtask

	initial
	begin
		repeat (3) @(posedge mclk);
		#1;
		rstn = 1'b1;
		lrstn = 1'b1;
		check("idle start", adc_start, 1'b0);
		check("idle pulse", int_n, 1'b1);
		check("idle busy", busy, 1'b0);
		check("idle result", result, 46'h0);
		trig();
		repeat (50) @(posedge mclk);
		check("power-down starts", n_start, 0);
		cfg_write(MODE_MASTER, 1'b0, CFG_RESET.chset, 1'b1);
		repeat (50) @(posedge mclk);
		check("untriggered starts", n_start, 0);
		run_one(12'h08a3);
		check("full order", order, 8'h1b);
		check("full starts", n_start, 4);
		check("pulse count", n_int, 1);
		check("pulse width", wid, INT_CYC);
		check("full results", result, RES_XYZT);
		// host appends two zero bits before any arithmetic
		check("temp sign", $signed({result.temp, 2'b00}) < 0, 1);
		// 0.24 K per count, kept in hundredths to stay in integers
		deg = ($signed({result.temp, 2'b00}) - TEMP_NOM_CNT) * 24;
		check("temp degrees", deg + TEMP_REF_DEGC * 100, -52700);
		wait_rd(rise, RD1_MAX_US);
		check("first read", result, RES_XYZT);
		wait_rd(tick, RDN_MAX_US);
		check("next read", result, RES_XYZT);
		cfg_write(MODE_MASTER, 1'b0, SET_XYZ, 1'b1);
		run_one(12'h0100);
		check("xyz order", order, 8'h06);
		check("xyz starts", n_start, 3);
		check("xyz results", result, RES_XYZ);
		wait_rd(rise, RD1_SR_MAX_US);
		check("first read sr", result, RES_XYZ);
		wait_rd(tick, RDN_SR_MAX_US);
		check("next read sr", result, RES_XYZ);
		cfg_write(MODE_MASTER, 1'b0, SET_XY, 1'b0);
		run_one(12'h0404);
		check("xy order", order, 8'h01);
		check("masked pulse", n_int, 0);
		check("xy results", result, RES_XY);
		lat = 8'h0a;
		cfg_write(MODE_FAST, 1'b0, SET_XY, 1'b1);
		repeat (200) @(posedge mclk);
		#1;
		check("fast restarts", n_start > 10, 1);
		check("fast busy", busy, 1'b1);
		cfg_write(MODE_POWER_DOWN, 1'b0, SET_XY, 1'b1);
		repeat (3) @(posedge mclk);
		n_start = 0;
		trig();
		repeat (100) @(posedge mclk);
		#1;
		check("stopped starts", n_start, 0);
		check("stopped busy", busy, 1'b0);
		lat = 8'h02;
		cfg_write(MODE_LOW_POWER, 1'b1, SET_XY, 1'b1);
		repeat (425) @(posedge mclk);
		check("lp fast rate", n_start, 16);
		// let the last end pulse finish, before the next timer tick
		repeat (15) @(posedge mclk);
		check("lp fast pulses", n_int, 8);
		cfg_write(MODE_POWER_DOWN, 1'b0, SET_XY, 1'b1);
		cfg_write(MODE_LOW_POWER, 1'b0, SET_XY, 1'b0);
		repeat (425) @(posedge mclk);
		check("lp slow rate", n_start, 4);
		check("lp no pulse", n_int, 0);
		close_out();
	end
endmodule
`default_nettype wire
